// >>> verilog/fms_top.sv
/*
  Flash access mode selection and program/data/I/O space decode.
  Assumes a CPU core presenting program, data-read and data-write requests
  in the same clock cycle, and a flash wrapper, block zero and external
  memory interface that act on the selects and strobes driven here.
*/
// Summary of operation
// - I/O write to mode port selects control register access, data ignored.
// - I/O read of mode port selects array access, returned data meaningless.
// - Mode port never returns stored contents; it is only a trigger address.
// - Control registers share array base; in register mode the array is unreachable.
// - In array mode control registers are hidden; shared addresses hit the array.
// - Four flash control registers are provided alongside the array.
// - Three selectable spaces, program, data and I/O, each 64K words.
// - Program, data-read and data-write buses decode independently in one cycle.
// - Program space spans at most 64K sixteen-bit words, on-chip blocks included.
// - Off-chip accesses drive the matching space strobe and access strobe low, one per cycle; write beats read beats fetch.
// - Placement bit one puts block zero in program space, zero sends it external.
// - Placement bit reads zero after reset, block zero in data space.
// - Boot select low routes program 0000h-7FFFh and reset vector on chip.
// - Boot select high routes program 0000h-7FFFh and reset vector off chip.
// - Reset vector is always fetched from program address 0000h.
// - Without external interface, program accesses never go off chip; unmapped addresses select no target.
`include "fms_params.svh"

module fms_top #(
  parameter bit HAS_EXT_IF = 1'b1
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic boot_memory_select_pin_i,
  input wire logic [`FMS_DATA_W-1:0] second_status_word_i,
  input wire logic prog_req_i,
  input wire logic prog_wr_i,
  input wire logic [`FMS_ADDR_W-1:0] program_address_bus_i,
  input wire logic dr_req_i,
  input wire logic dr_io_i,
  input wire logic [`FMS_ADDR_W-1:0] data_read_address_bus_i,
  input wire logic dw_req_i,
  input wire logic dw_io_i,
  input wire logic [`FMS_ADDR_W-1:0] data_write_address_bus_i,
  output logic flash_reg_mode_o,
  output logic flash_powerdown_ok_o,
  output logic flash_array_sel_o,
  output logic [`FMS_CTRL_REGS-1:0] flash_ctrl_sel_o,
  output logic flash_ctrl_wr_o,
  output logic b0_prog_sel_o,
  output logic dr_internal_o,
  output logic dw_internal_o,
  output logic block_zero_placement_o,
  output logic io_ack_o,
  output logic [`FMS_DATA_W-1:0] io_rdata_o,
  output logic boot_vector_fetch_o,
  output logic reset_vector_onchip_o,
  output logic program_space_strobe_n_o,
  output logic data_space_strobe_n_o,
  output logic io_space_strobe_n_o,
  output logic external_access_strobe_n_o,
  output logic ext_wr_o,
  output logic [`FMS_ADDR_W-1:0] ext_addr_o
);

  fms_dec_if dec_bus ();

  logic mp_meta_q;
  logic mp_sync_q;
  logic cnf_q;
  fms_pkg::fms_mode_e mode_q;
  fms_pkg::fms_mode_e mode_d;
  logic mode_wr_hit;
  logic mode_rd_hit;
  logic prog_flash;
  logic prog_ext;
  logic dr_ext;
  logic dw_ext;
  logic ctrl_hit;
  logic first_fetch_q;
  logic vec_onchip_q;
  logic io_ack_q;
  logic [`FMS_DATA_W-1:0] io_rdata_q;
  logic ps_n_q;
  logic ds_n_q;
  logic is_n_q;
  logic external_access_strobe_n_q;
  logic ext_wr_q;
  fms_pkg::fms_addr_t ext_addr_q;

  // Boot select is a pin, so it is brought in through two flops
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mp_meta_q <= 1'b0;
      mp_sync_q <= 1'b0;
    end
    else
    begin
      mp_meta_q <= boot_memory_select_pin_i;
      mp_sync_q <= mp_meta_q;
    end
  end

  // Copy of the placement bit; one cycle behind the status word
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnf_q <= 1'b0;
    else
      cnf_q <= second_status_word_i[`FMS_CNF_BIT];
  end

  assign dec_bus.addr = program_address_bus_i;
  assign dec_bus.block_zero_placement_bit = cnf_q;
  assign dec_bus.boot_memory_select_pin = mp_sync_q;
  assign dec_bus.has_ext = HAS_EXT_IF;

  fms_prog_decode u_prog_decode (
    .d (dec_bus)
  );

  // Mode port hits; only the address matters, never the data
  assign mode_wr_hit = dw_req_i && dw_io_i &&
                       (data_write_address_bus_i == `FMS_MODE_REG_ADDR);
  assign mode_rd_hit = dr_req_i && dr_io_i &&
                       (data_read_address_bus_i == `FMS_MODE_REG_ADDR);

  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      fms_pkg::mode_array:
      begin
        if (mode_wr_hit)
          mode_d = fms_pkg::mode_regs;
      end
      fms_pkg::mode_regs:
      begin
        // A write in the same cycle keeps register mode
        if (mode_rd_hit && !mode_wr_hit)
          mode_d = fms_pkg::mode_array;
      end
    endcase
  end

  // Registered so the new mode governs the next access, not the current one
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mode_q <= fms_pkg::mode_array;
    else
      mode_q <= mode_d;
  end

  assign flash_reg_mode_o = (mode_q == fms_pkg::mode_regs);
  // Array idle in register mode, so it may be powered down safely
  assign flash_powerdown_ok_o = (mode_q == fms_pkg::mode_regs);

  // Program bus decode; independent of both data buses
  assign prog_flash = prog_req_i && (dec_bus.tgt == fms_pkg::ptgt_flash);
  assign prog_ext = prog_req_i && (dec_bus.tgt == fms_pkg::ptgt_ext);

  // Array writes are not direct memory writes and are dropped
  assign flash_array_sel_o = prog_flash && !prog_wr_i &&
                             (mode_q == fms_pkg::mode_array);
  assign ctrl_hit = prog_flash && dec_bus.in_ctrl &&
                    (mode_q == fms_pkg::mode_regs);

  genvar gi;
  generate
    for (gi = 0; gi < `FMS_CTRL_REGS; gi++)
    begin : g_ctrl_sel
      assign flash_ctrl_sel_o[gi] =
        ctrl_hit && (dec_bus.ctrl_idx == `FMS_CTRL_IDX_W'(gi));
    end
  endgenerate

  assign flash_ctrl_wr_o = ctrl_hit && prog_wr_i;
  assign b0_prog_sel_o = prog_req_i && (dec_bus.tgt == fms_pkg::ptgt_b0);

  // Data buses decode with the shared space function
  assign dr_ext = dr_req_i &&
                  fms_pkg::fms_data_is_ext(data_read_address_bus_i, dr_io_i,
                                           HAS_EXT_IF);
  assign dw_ext = dw_req_i &&
                  fms_pkg::fms_data_is_ext(data_write_address_bus_i, dw_io_i,
                                           HAS_EXT_IF);
  assign dr_internal_o = dr_req_i && !dr_io_i && !dr_ext;
  assign dw_internal_o = dw_req_i && !dw_io_i && !dw_ext;
  assign block_zero_placement_o = cnf_q;

  // Mode port answers with a fixed pattern, never stored state
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      io_ack_q <= 1'b0;
      io_rdata_q <= `FMS_IO_RDATA;
    end
    else
    begin
      io_ack_q <= mode_wr_hit || mode_rd_hit;
      io_rdata_q <= `FMS_IO_RDATA;
    end
  end

  assign io_ack_o = io_ack_q;
  assign io_rdata_o = io_rdata_q;

  // First program fetch after reset is the reset vector fetch
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      first_fetch_q <= 1'b1;
      vec_onchip_q <= 1'b0;
    end
    else if (first_fetch_q && prog_req_i &&
             (program_address_bus_i == `FMS_RESET_VECTOR))
    begin
      first_fetch_q <= 1'b0;
      vec_onchip_q <= prog_flash;
    end
  end

  assign boot_vector_fetch_o = first_fetch_q && prog_req_i &&
                               (program_address_bus_i == `FMS_RESET_VECTOR);
  assign reset_vector_onchip_o = vec_onchip_q;

  // One external bus: write beats read beats fetch; the CPU must not
  // issue two off-chip accesses in one cycle, the loser is not driven
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ps_n_q <= `FMS_STROBE_OFF;
      ds_n_q <= `FMS_STROBE_OFF;
      is_n_q <= `FMS_STROBE_OFF;
      external_access_strobe_n_q <= `FMS_STROBE_OFF;
      ext_wr_q <= 1'b0;
      ext_addr_q <= '0;
    end
    else
    begin
      ps_n_q <= `FMS_STROBE_OFF;
      ds_n_q <= `FMS_STROBE_OFF;
      is_n_q <= `FMS_STROBE_OFF;
      external_access_strobe_n_q <= `FMS_STROBE_OFF;
      ext_wr_q <= 1'b0;
      if (dw_ext)
      begin
        ds_n_q <= dw_io_i ? `FMS_STROBE_OFF : `FMS_STROBE_ON;
        is_n_q <= dw_io_i ? `FMS_STROBE_ON : `FMS_STROBE_OFF;
        external_access_strobe_n_q <= `FMS_STROBE_ON;
        ext_wr_q <= 1'b1;
        ext_addr_q <= data_write_address_bus_i;
      end
      else if (dr_ext)
      begin
        ds_n_q <= dr_io_i ? `FMS_STROBE_OFF : `FMS_STROBE_ON;
        is_n_q <= dr_io_i ? `FMS_STROBE_ON : `FMS_STROBE_OFF;
        external_access_strobe_n_q <= `FMS_STROBE_ON;
        ext_addr_q <= data_read_address_bus_i;
      end
      else if (prog_ext)
      begin
        ps_n_q <= `FMS_STROBE_ON;
        external_access_strobe_n_q <= `FMS_STROBE_ON;
        ext_wr_q <= prog_wr_i;
        ext_addr_q <= program_address_bus_i;
      end
    end
  end

  assign program_space_strobe_n_o = ps_n_q;
  assign data_space_strobe_n_o = ds_n_q;
  assign io_space_strobe_n_o = is_n_q;
  assign external_access_strobe_n_o = external_access_strobe_n_q;
  assign ext_wr_o = ext_wr_q;
  assign ext_addr_o = ext_addr_q;

endmodule : fms_top

// >>> verilog/fms_params.svh
/*
  Constants for the flash access mode and program memory decode block.
  Assumes a 16-bit address in each of the program, data and I/O spaces.
*/
`ifndef FMS_PARAMS_SVH
`define FMS_PARAMS_SVH

`define FMS_ADDR_W 16
`define FMS_DATA_W 16
`define FMS_MODE_REG_ADDR 16'hff0f
`define FMS_FLASH_HI 16'h7fff
`define FMS_RSVD_LO 16'hfe00
`define FMS_RSVD_HI 16'hfeff
`define FMS_B0_LO 16'hff00
`define FMS_DATA_EXT_LO 16'h8000
`define FMS_RESET_VECTOR 16'h0000
`define FMS_CNF_BIT 12
`define FMS_CTRL_REGS 4
`define FMS_CTRL_IDX_W 2
`define FMS_IO_RDATA 16'h0000
`define FMS_STROBE_OFF 1'b1
`define FMS_STROBE_ON 1'b0

`endif

// >>> verilog/fms_pkg.sv
/*
  Types and shared decode for the flash access mode block.
  Assumes fms_params.svh is on the include path.
*/
`include "fms_params.svh"

package fms_pkg;

  typedef logic [`FMS_ADDR_W-1:0] fms_addr_t;

  typedef enum logic {mode_array, mode_regs} fms_mode_e;

  typedef enum logic [1:0] {ptgt_flash, ptgt_b0, ptgt_ext, ptgt_none} fms_ptgt_e;

  // Data space upper half and all I/O except the mode port live off chip
  function automatic logic fms_data_is_ext(input fms_addr_t addr, input logic is_io,
                                           input logic has_ext);
    logic ext;
    ext = is_io ? (addr != `FMS_MODE_REG_ADDR) : (addr >= `FMS_DATA_EXT_LO);
    return ext & has_ext;
  endfunction : fms_data_is_ext

endpackage : fms_pkg

// >>> verilog/fms_dec_if.sv
/*
  Carrier between the top block and the program space decoder.
  Assumes both ends run from the same clock and are purely combinational here.
*/
`include "fms_params.svh"

interface fms_dec_if;
  fms_pkg::fms_addr_t addr;
  logic block_zero_placement_bit;
  logic boot_memory_select_pin;
  logic has_ext;
  fms_pkg::fms_ptgt_e tgt;
  logic in_ctrl;
  logic [`FMS_CTRL_IDX_W-1:0] ctrl_idx;

  modport top (output addr, output block_zero_placement_bit, output boot_memory_select_pin, output has_ext,
               input tgt, input in_ctrl, input ctrl_idx);
  modport dec (input addr, input block_zero_placement_bit, input boot_memory_select_pin, input has_ext,
               output tgt, output in_ctrl, output ctrl_idx);
endinterface : fms_dec_if

// >>> verilog/fms_prog_decode.sv
/*
  Program space address decoder: flash, dual-access block zero or external.
  Assumes the placement bit and boot select level are already in the clock domain.
*/
`include "fms_params.svh"

module fms_prog_decode (
  fms_dec_if.dec d
);

  always_comb
  begin
    d.tgt = fms_pkg::ptgt_ext;
    if (d.addr <= `FMS_FLASH_HI)
    begin
      // Variants without external bus always boot and run from chip
      if (!d.boot_memory_select_pin || !d.has_ext)
        d.tgt = fms_pkg::ptgt_flash;
      else
        d.tgt = fms_pkg::ptgt_ext;
    end
    else if (d.addr >= `FMS_B0_LO)
    begin
      if (d.block_zero_placement_bit)
        d.tgt = fms_pkg::ptgt_b0;
      else
        d.tgt = d.has_ext ? fms_pkg::ptgt_ext : fms_pkg::ptgt_none;
    end
    else if (d.addr >= `FMS_RSVD_LO && d.addr <= `FMS_RSVD_HI)
    begin
      // Hole left reserved while the block sits in program space
      if (d.block_zero_placement_bit)
        d.tgt = fms_pkg::ptgt_none;
      else
        d.tgt = d.has_ext ? fms_pkg::ptgt_ext : fms_pkg::ptgt_none;
    end
    else
    begin
      d.tgt = d.has_ext ? fms_pkg::ptgt_ext : fms_pkg::ptgt_none;
    end
  end

  // Control registers share the base of the array
  assign d.in_ctrl = (d.addr < `FMS_ADDR_W'(`FMS_CTRL_REGS));
  assign d.ctrl_idx = d.addr[`FMS_CTRL_IDX_W-1:0];

endmodule : fms_prog_decode

// >>> tb/fms_top_checker.sv
/* Concurrent checks on the ports of fms_top.
   Assumes the external interface is present. */
module fms_chk (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [15:0] second_status_word_i,
  input wire logic prog_req_i,
  input wire logic prog_wr_i,
  input wire logic [15:0] program_address_bus_i,
  input wire logic dr_req_i,
  input wire logic dr_io_i,
  input wire logic [15:0] data_read_address_bus_i,
  input wire logic dw_req_i,
  input wire logic dw_io_i,
  input wire logic [15:0] data_write_address_bus_i,
  input wire logic flash_reg_mode_o,
  input wire logic flash_array_sel_o,
  input wire logic [3:0] flash_ctrl_sel_o,
  input wire logic b0_prog_sel_o,
  input wire logic block_zero_placement_o,
  input wire logic io_ack_o,
  input wire logic [15:0] io_rdata_o,
  input wire logic boot_vector_fetch_o,
  input wire logic program_space_strobe_n_o,
  input wire logic external_access_strobe_n_o,
  input wire logic [15:0] ext_addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic wr_hit;
  logic rd_hit;
  assign wr_hit = dw_req_i && dw_io_i && data_write_address_bus_i == 16'hff0f;
  assign rd_hit = dr_req_i && dr_io_i && data_read_address_bus_i == 16'hff0f;
  sequence s_mode_acc;
    wr_hit || rd_hit;
  endsequence
  sequence s_ack;
    io_ack_o && io_rdata_o == 16'h0000;
  endsequence
  AST_WR_MODE: assert property (wr_hit |=> flash_reg_mode_o)
    else $error("mode write did not select registers");
  AST_RD_MODE: assert property (rd_hit && !wr_hit |=> !flash_reg_mode_o)
    else $error("mode read did not select array");
  AST_ACK: assert property (s_mode_acc |=> s_ack)
    else $error("mode port ack or data wrong");
  AST_ARRAY_OFF: assert property (flash_reg_mode_o |-> !flash_array_sel_o)
    else $error("array selected in register mode");
  AST_CTRL_HID: assert property (!flash_reg_mode_o |-> flash_ctrl_sel_o == 4'h0)
    else $error("control register selected in array mode");
  AST_CTRL_IDX: assert property (flash_ctrl_sel_o != 4'h0 |-> prog_req_i &&
    flash_ctrl_sel_o == 4'h1 << program_address_bus_i[1:0])
    else $error("control register select wrong");
  AST_EXT_PROG: assert property (prog_req_i && !dr_req_i && !dw_req_i &&
    program_address_bus_i inside {[16'h8000:16'hfdff]} |=> !program_space_strobe_n_o
    && !external_access_strobe_n_o && ext_addr_o == $past(program_address_bus_i))
    else $error("external program strobe missing");
  AST_B0: assert property (prog_req_i && program_address_bus_i >= 16'hff00
    |-> b0_prog_sel_o == block_zero_placement_o)
    else $error("block zero select wrong");
  AST_PLACE: assert property ($past(resetn_i)
    |-> block_zero_placement_o == $past(second_status_word_i[12]))
    else $error("placement bit not mirrored");
  AST_VEC: assert property (boot_vector_fetch_o
    |-> prog_req_i && program_address_bus_i == 16'h0000)
    else $error("vector fetch away from 0000");
  AST_FLASH: assert property (flash_array_sel_o
    |-> prog_req_i && !prog_wr_i && program_address_bus_i <= 16'h7fff)
    else $error("flash selected outside its range");
endmodule : fms_chk
bind fms_top fms_chk u_chk (.*);

// >>> tb/fms_cpu_model.sv
/* CPU core model driving program, data-read and data-write requests.
   Assumes the bench calls its tasks from one process. */
module fms_cpu_model (
  input wire logic mclk_i,
  output logic preq_o,
  output logic pwr_o,
  output logic [15:0] pa_o,
  output logic drq_o,
  output logic dio_o,
  output logic [15:0] da_o,
  output logic wrq_o,
  output logic wio_o,
  output logic [15:0] wa_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {preq_o, pwr_o, drq_o, dio_o, wrq_o, wio_o} = 6'h00;
    {pa_o, da_o, wa_o} = 48'h0;
  end
  // Idle buses show inverted addresses so nothing leans on a stale value
  task automatic acc(input logic [2:0] rq, input logic pw, input logic io,
                     input logic [15:0] pa, input logic [15:0] a);
    @(posedge mclk_i);
    preq_o <= rq[2];
    pwr_o <= pw;
    pa_o <= rq[2] ? pa : ~pa_o;
    drq_o <= rq[1];
    wrq_o <= rq[0];
    dio_o <= io;
    wio_o <= io;
    da_o <= rq[1] ? a : ~da_o;
    wa_o <= rq[0] ? a : ~wa_o;
  endtask : acc
  // Flash goes to register mode before the deepest low power mode
  task automatic power_down;
    acc(3'b001, 1'b0, 1'b1, 16'h0000, 16'hff0f);
  endtask : power_down
endmodule : fms_cpu_model

// >>> tb/tb.sv
/* Self-checking bench for fms_top with a CPU core model.
   Assumes the default parameter with the external interface. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, resetn_i, boot_memory_select_pin_i;
  logic [15:0] second_status_word_i, program_address_bus_i, io_rdata_o, ext_addr_o;
  logic [15:0] data_read_address_bus_i, data_write_address_bus_i;
  logic prog_req_i, prog_wr_i, dr_req_i, dr_io_i, dw_req_i, dw_io_i;
  logic flash_reg_mode_o, flash_powerdown_ok_o, flash_array_sel_o, b0_prog_sel_o;
  logic dr_internal_o, block_zero_placement_o, io_ack_o, boot_vector_fetch_o;
  logic reset_vector_onchip_o, program_space_strobe_n_o, data_space_strobe_n_o;
  logic io_space_strobe_n_o, ext_wr_o, dw_internal_o, external_access_strobe_n_o;
  logic flash_ctrl_wr_o;
  logic [3:0] flash_ctrl_sel_o;
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] ra, rb;
  fms_top u_dut (.*);
  fms_cpu_model u_cpu (.mclk_i(mclk_i), .preq_o(prog_req_i), .pwr_o(prog_wr_i),
    .pa_o(program_address_bus_i), .drq_o(dr_req_i), .dio_o(dr_io_i),
    .da_o(data_read_address_bus_i), .wrq_o(dw_req_i), .wio_o(dw_io_i),
    .wa_o(data_write_address_bus_i));
  function automatic logic exp_int(input logic [15:0] a);
    return a < 16'h8000;
  endfunction : exp_int
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic [2:0] rq, input logic io, input logic [15:0] pa,
                     input logic [15:0] a);
    u_cpu.acc(rq, 1'b0, io, pa, a);
    #1;
  endtask : acc
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    resetn_i = 1'b0;
    boot_memory_select_pin_i = 1'b0;
    second_status_word_i = 16'h0000;
    void'($urandom(85101));
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1;
    chk("mode", 16'h0, flash_reg_mode_o);
    chk("place", 16'h0, block_zero_placement_o);
    acc(3'b100, 1'b0, 16'h0000, 16'h0);
    chk("array", 16'h1, flash_array_sel_o);
    chk("vector", 16'h1, boot_vector_fetch_o);
    acc(3'b000, 1'b0, 16'h0, 16'h0);
    chk("onchip", 16'h1, reset_vector_onchip_o);
    $display("boot test done");
    u_cpu.power_down();
    acc(3'b100, 1'b0, 16'h0002, 16'h0);
    chk("pdown", 16'h1, flash_powerdown_ok_o);
    chk("ctrl", 16'h4, flash_ctrl_sel_o);
    chk("array", 16'h0, flash_array_sel_o);
    u_cpu.acc(3'b100, 1'b1, 1'b0, 16'h0001, 16'h0);
    #1;
    chk("ctrlwr", 16'h1, flash_ctrl_wr_o);
    acc(3'b110, 1'b1, 16'h0003, 16'hff0f);
    chk("ctrl", 16'h8, flash_ctrl_sel_o);
    acc(3'b100, 1'b0, 16'h0002, 16'h0);
    chk("mode", 16'h0, flash_reg_mode_o);
    chk("ack", 16'h1, io_ack_o);
    chk("rdata", 16'h0, io_rdata_o);
    chk("ctrl", 16'h0, flash_ctrl_sel_o);
    chk("array", 16'h1, flash_array_sel_o);
    $display("mode test done");
    repeat (40)
    begin
      ra = 16'($urandom);
      rb = 16'($urandom) & 16'h7fff;
      acc(3'b111, 1'b0, rb, ra);
      chk("drint", {15'h0, exp_int(ra)}, dr_internal_o);
      chk("dwint", {15'h0, exp_int(ra)}, dw_internal_o);
      chk("array", 16'h1, flash_array_sel_o);
    end
    $display("random test done");
    @(posedge mclk_i);
    second_status_word_i <= 16'($urandom) | 16'h1000;
    acc(3'b100, 1'b0, 16'hff10, 16'h0);
    chk("b0", 16'h1, b0_prog_sel_o);
    acc(3'b100, 1'b0, 16'hfe10, 16'h0);
    chk("b0", 16'h0, b0_prog_sel_o);
    @(posedge mclk_i);
    second_status_word_i <= 16'($urandom) & 16'hefff;
    acc(3'b100, 1'b0, 16'hff10, 16'h0);
    chk("ps", 16'h1, program_space_strobe_n_o);
    acc(3'b010, 1'b0, 16'h0, 16'h8000);
    chk("ps", 16'h0, program_space_strobe_n_o);
    chk("addr", 16'hff10, ext_addr_o);
    chk("external_access_strobe", 16'h0, external_access_strobe_n_o);
    acc(3'b001, 1'b1, 16'h0, 16'h0100);
    chk("ds", 16'h0, data_space_strobe_n_o);
    chk("wr", 16'h0, ext_wr_o);
    acc(3'b000, 1'b0, 16'h0, 16'h0);
    chk("is", 16'h0, io_space_strobe_n_o);
    chk("wr", 16'h1, ext_wr_o);
    chk("addr", 16'h0100, ext_addr_o);
    $display("external test done");
    @(posedge mclk_i);
    boot_memory_select_pin_i <= 1'b1;
    repeat (3) acc(3'b000, 1'b0, 16'h0, 16'h0);
    acc(3'b100, 1'b0, 16'h0010, 16'h0);
    chk("array", 16'h0, flash_array_sel_o);
    acc(3'b000, 1'b0, 16'h0, 16'h0);
    chk("ps", 16'h0, program_space_strobe_n_o);
    chk("addr", 16'h0010, ext_addr_o);
    $display("boot pin test done");
    summarize();
  end
endmodule : tb
